// ==== windowed_watchdog_timer.sv ====
// Windowed watchdog timer with prescaler, postscaler and wake-up
// How it works
// - Counts low-power RC ticks; enable powers oscillator
// - Prescaler divides by 32 or 128
// - Base period 1 ms or 4 ms
// - Four-bit postscaler field selects sixteen ratios
// - Any device reset clears all counts
// - Oscillator switch completion clears all counts
// - Power-save instruction clears all counts
// - Leaving sleep or idle clears all counts
// - Clear instruction clears all counts
// - Keeps counting in sleep and idle
// - Timeout in low power wakes core
// - Hard fuse keeps watchdog always running
// - Otherwise soft enable bit gates running
// - Device reset clears soft enable bit
// - Early clear in window mode resets
// - Timeout sets sticky flag; software clears
// - Prescale select one means divide-by-128
// - Window disable one means non-window mode
// - Hard fuse overrides soft enable clearing
// - Codes 1111 and 1110 give 32768, 16384
`include "wdt_consts.svh"
module windowed_watchdog_timer
  import wdt_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  // Configuration word bits 6..0
  input  wire logic [6:0] watchdog_config_word,
  // Core events
  input  wire logic       device_reset,
  input  wire logic       osc_switch_done,
  input  wire logic       power_save_instr,
  input  wire logic       power_save_exit,
  input  wire logic       clear_watchdog_instr,
  // Software control bits
  input  wire logic       soft_enable_wr,
  input  wire logic       soft_enable_wdata,
  input  wire logic       timeout_flag_clr,
  // Status and actions
  output logic            soft_enable_bit,
  output logic            timeout_flag,
  output logic            low_power_rc_osc_en,
  output logic            wdt_reset_req,
  output logic            wake_req,
  output logic            in_low_power
);
  logic       tick;
  logic [6:0] pre_cnt;
  logic [`POST_W-1:0] post_cnt;
  core_mode_t mode;
  logic [6:0] next_pre_cnt;
  logic [`POST_W-1:0] next_post_cnt;
  core_mode_t next_mode;
  logic       next_soft_enable_bit;
  logic       next_timeout_flag;
  logic       next_wdt_reset_req;
  logic       next_wake_req;
  logic       next_osc_en;
  logic       running;
  logic       pre_wrap;
  logic       post_wrap;
  logic       clear_all;
  logic       early_clear;
  logic [6:0] pre_max;
  logic [`POST_W-1:0] post_max;
  logic [3:0] post_code;
  logic       hard_enable_fuse;
  logic       window_disable;

  assign post_code        = watchdog_config_word[`CFG_POST_MSB:`CFG_POST_LSB];
  assign hard_enable_fuse = watchdog_config_word[`CFG_HARDEN_BIT];
  assign window_disable   = watchdog_config_word[`CFG_WINDOW_DISABLE_BIT];
  assign pre_max  = watchdog_config_word[`CFG_PRESEL_BIT] ? `PRE_LONG_MAX
                                                          : `PRE_SHORT_MAX;
  assign post_max = (`POST_W'(1) << post_code) - `POST_W'(1);
  assign running  = hard_enable_fuse | soft_enable_bit;
  assign pre_wrap  = tick && (pre_cnt == pre_max);
  assign post_wrap = pre_wrap && (post_cnt == post_max);
  // Early means before the last quarter of the postscaled period
  assign early_clear = clear_watchdog_instr && !window_disable && running &&
                       (mode == run_mode) &&
                       (post_cnt < post_max - (post_max >> 2));
  assign clear_all = device_reset | osc_switch_done | power_save_instr |
                     power_save_exit | clear_watchdog_instr;

  low_power_rc_osc_tick_gen u_low_power_rc_osc (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .osc_on  (low_power_rc_osc_en),
    .tick    (tick)
  );

  always_comb begin
    next_pre_cnt         = pre_cnt;
    next_post_cnt        = post_cnt;
    next_mode            = mode;
    next_soft_enable_bit = soft_enable_bit;
    next_timeout_flag    = timeout_flag;
    next_wdt_reset_req   = 1'b0;
    next_wake_req        = 1'b0;
    next_osc_en          = running;
    if (soft_enable_wr) begin
      next_soft_enable_bit = soft_enable_wdata;
    end
    if (timeout_flag_clr) begin
      next_timeout_flag = 1'b0;
    end
    if (power_save_instr) begin
      next_mode = low_power_mode;
    end else if (power_save_exit) begin
      next_mode = run_mode;
    end
    if (clear_all || !running) begin
      next_pre_cnt  = '0;
      next_post_cnt = '0;
    end else if (pre_wrap) begin
      next_pre_cnt  = '0;
      next_post_cnt = post_wrap ? '0 : post_cnt + `POST_W'(1);
    end else if (tick) begin
      next_pre_cnt = pre_cnt + 7'h01;
    end
    if (running && post_wrap && !clear_all) begin
      next_timeout_flag = 1'b1;
      if (mode == low_power_mode) begin
        next_wake_req = 1'b1;
        next_mode     = run_mode;
      end else begin
        next_wdt_reset_req = 1'b1;
      end
    end
    if (early_clear) begin
      next_wdt_reset_req = 1'b1;
    end
    if (device_reset) begin
      next_soft_enable_bit = 1'b0;
      next_mode            = run_mode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pre_cnt             <= '0;
      post_cnt            <= '0;
      mode                <= run_mode;
      soft_enable_bit     <= 1'b0;
      timeout_flag        <= 1'b0;
      wdt_reset_req       <= 1'b0;
      wake_req            <= 1'b0;
      low_power_rc_osc_en <= 1'b0;
      in_low_power        <= 1'b0;
    end else if (clk_en) begin
      pre_cnt             <= next_pre_cnt;
      post_cnt            <= next_post_cnt;
      mode                <= next_mode;
      soft_enable_bit     <= next_soft_enable_bit;
      timeout_flag        <= next_timeout_flag;
      wdt_reset_req       <= next_wdt_reset_req;
      wake_req            <= next_wake_req;
      low_power_rc_osc_en <= next_osc_en;
      in_low_power        <= (next_mode == low_power_mode);
    end
  end

  // Checks
  property p_clear_zeroes;
    @(posedge ref_clk) disable iff (srst) (clk_en && clear_all) |=> (pre_cnt == 7'h00);
  endproperty
  a_clear_zeroes: assert property (p_clear_zeroes) else $error("clear missed");
  property p_reset_enable;
    @(posedge ref_clk) disable iff (srst) (clk_en && device_reset) |=> !soft_enable_bit;
  endproperty
  a_reset_enable: assert property (p_reset_enable) else $error("soft enable kept");
  property p_flag_sticky;
    @(posedge ref_clk) disable iff (srst)
      (timeout_flag && !timeout_flag_clr) |=> timeout_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
  property p_wake;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && running && post_wrap && !clear_all && mode == low_power_mode)
      |=> wake_req && !wdt_reset_req && timeout_flag;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_run_reset;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && running && post_wrap && !clear_all && mode == run_mode)
      |=> wdt_reset_req && timeout_flag;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("no reset");
  property p_early;
    @(posedge ref_clk) disable iff (srst) (clk_en && early_clear) |=> wdt_reset_req;
  endproperty
  a_early: assert property (p_early) else $error("early clear ignored");
  property p_hard;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && hard_enable_fuse) |=> low_power_rc_osc_en;
  endproperty
  a_hard: assert property (p_hard) else $error("oscillator off");
  property p_idle_count;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && tick && running && !clear_all && !pre_wrap && mode == low_power_mode)
      |=> pre_cnt == $past(pre_cnt) + 7'h01;
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("stalled in sleep");
  property p_switch_clear;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && osc_switch_done) |=> (pre_cnt == 7'h00 && post_cnt == '0);
  endproperty
  a_switch_clear: assert property (p_switch_clear) else $error("switch kept count");
  property p_sleep_clear;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && power_save_instr) |=> (pre_cnt == 7'h00 && post_cnt == '0);
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("entry kept count");
  property p_exit_clear;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && power_save_exit) |=> (pre_cnt == 7'h00 && post_cnt == '0);
  endproperty
  a_exit_clear: assert property (p_exit_clear) else $error("exit kept count");
  property p_soft_write;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && soft_enable_wr && !device_reset)
      |=> soft_enable_bit == $past(soft_enable_wdata);
  endproperty
  a_soft_write: assert property (p_soft_write) else $error("soft write lost");
  property p_gated;
    @(posedge ref_clk) disable iff (srst)
      (clk_en && !running) |=> (pre_cnt == 7'h00 && post_cnt == '0);
  endproperty
  a_gated: assert property (p_gated) else $error("counting while off");
  property p_osc_follow;
    @(posedge ref_clk) disable iff (srst)
      clk_en |=> low_power_rc_osc_en == $past(running);
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("oscillator mismatch");
  c_wake: cover property (@(posedge ref_clk) wake_req);
  c_low_power: cover property (@(posedge ref_clk) in_low_power);
  c_reset: cover property (@(posedge ref_clk) wdt_reset_req);
  c_early: cover property (@(posedge ref_clk) early_clear);
endmodule

// ==== wdt_consts.svh ====
// Constants for the windowed watchdog timer
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define LOW_POWER_RC_OSC_FREQ_HZ      32000
`define REF_FREQ_HZ       100000000
`define LOW_POWER_RC_OSC_HALF_CYCLES  ((`REF_FREQ_HZ / `LOW_POWER_RC_OSC_FREQ_HZ) / 2)
`define TICK_CNT_W        12
`define PRE_SHORT_MAX     7'h1f
`define PRE_LONG_MAX      7'h7f
`define CFG_POST_LSB      0
`define CFG_POST_MSB      3
`define CFG_PRESEL_BIT    4
`define CFG_HARDEN_BIT    5
`define CFG_WINDOW_DISABLE_BIT    6
`define POST_W            16
`endif

// ==== wdt_pkg.sv ====
// Types for the windowed watchdog timer
package wdt_pkg;
  typedef enum logic [1:0] {run_mode, low_power_mode} core_mode_t;
endpackage

// ==== low_power_rc_osc_tick_gen.sv ====
// Low-power RC oscillator model: emits one tick per 32 kHz period
`include "wdt_consts.svh"
module low_power_rc_osc_tick_gen (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  // Control
  input  wire logic osc_on,
  // Tick out
  output logic      tick
);
  logic [`TICK_CNT_W-1:0] cnt;
  logic [`TICK_CNT_W-1:0] next_cnt;
  logic                   next_tick;

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!osc_on) begin
      next_cnt = '0;
    end else if (cnt == `TICK_CNT_W'(2 * `LOW_POWER_RC_OSC_HALF_CYCLES - 1)) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + `TICK_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (clk_en) begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ==== core_model.sv ====
// Processor core model: issues clear and power-save instructions
module core_model
  import wdt_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // From watchdog
  input  wire logic wake_req,
  // To watchdog
  output logic      power_save_instr,
  output logic      power_save_exit,
  output logic      clear_watchdog_instr,
  output logic      timeout_flag_clr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    power_save_instr     = 1'b0;
    power_save_exit      = 1'b0;
    clear_watchdog_instr = 1'b0;
    timeout_flag_clr     = 1'b0;
  end

  // One-cycle instruction pulse: 0 power save, 1 exit, 2 clear
  task automatic pulse(input int sel);
    @(negedge ref_clk);
    case (sel)
      0: power_save_instr = 1'b1;
      1: power_save_exit = 1'b1;
      default: clear_watchdog_instr = 1'b1;
    endcase
    @(negedge ref_clk);
    power_save_instr     = 1'b0;
    power_save_exit      = 1'b0;
    clear_watchdog_instr = 1'b0;
  endtask

  // Software clears the timeout flag after a wake-up
  always @(negedge ref_clk) begin
    timeout_flag_clr <= (wake_req === 1'b1);
  end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the windowed watchdog timer
module testbench
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: %s", $time, msg); end end

  logic       ref_clk, srst, clk_en, device_reset, osc_switch_done;
  logic       soft_enable_wr, soft_enable_wdata, power_save_instr, power_save_exit;
  logic       clear_watchdog_instr, timeout_flag_clr, soft_enable_bit, timeout_flag;
  logic       low_power_rc_osc_en, wdt_reset_req, wake_req, in_low_power;
  logic [6:0] cfg;
  int         num_errors, cmp_count, cycles, n, rst, seed;

  windowed_watchdog_timer i_windowed_watchdog_timer (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .watchdog_config_word(cfg),
    .device_reset(device_reset), .osc_switch_done(osc_switch_done),
    .power_save_instr(power_save_instr), .power_save_exit(power_save_exit),
    .clear_watchdog_instr(clear_watchdog_instr), .soft_enable_wr(soft_enable_wr),
    .soft_enable_wdata(soft_enable_wdata), .timeout_flag_clr(timeout_flag_clr),
    .soft_enable_bit(soft_enable_bit), .timeout_flag(timeout_flag),
    .low_power_rc_osc_en(low_power_rc_osc_en), .wdt_reset_req(wdt_reset_req),
    .wake_req(wake_req), .in_low_power(in_low_power));

  core_model i_core_model (
    .ref_clk(ref_clk), .wake_req(wake_req), .power_save_instr(power_save_instr),
    .power_save_exit(power_save_exit), .clear_watchdog_instr(clear_watchdog_instr),
    .timeout_flag_clr(timeout_flag_clr));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 103000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // Write soft enable, then let it settle
  task automatic sw(input logic v);
    @(negedge ref_clk);
    soft_enable_wr    = 1'b1;
    soft_enable_wdata = v;
    @(negedge ref_clk);
    soft_enable_wr    = 1'b0;
    cyc(2);
  endtask

  // Count cycles until wake (sel 0) or reset (sel 1), counting resets seen
  task automatic wait_pulse(input int sel, input int lim);
    n   = 0;
    rst = 0;
    while (n < lim && !(sel ? wdt_reset_req === 1'b1 : wake_req === 1'b1)) begin
      @(negedge ref_clk);
      n++;
      if (wdt_reset_req === 1'b1) rst++;
    end
  endtask

  initial begin
    seed = $urandom(32'h5bd0);
    {srst, clk_en, device_reset, osc_switch_done} = 4'hc;
    {soft_enable_wr, soft_enable_wdata} = 2'h0;
    cfg = 7'h40;
    cyc(10);
    srst = 1'b0;
    cyc(1);
    `CHK({soft_enable_bit, timeout_flag, low_power_rc_osc_en}, 3'h0, "after reset")
    sw(1'b1);
    `CHK(soft_enable_bit, 1'b1, "soft enable set")
    `CHK(low_power_rc_osc_en, 1'b1, "oscillator on")
    sw(1'b0);
    `CHK(low_power_rc_osc_en, 1'b0, "soft disable")
    cfg[5] = 1'b1;
    cyc(2);
    `CHK(low_power_rc_osc_en, 1'b1, "fuse enables")
    sw(1'b0);
    `CHK(low_power_rc_osc_en, 1'b1, "fuse overrides clear")
    cfg = 7'h00;
    cyc(2);
    for (int k = 0; k < 4; k++) begin
      cfg = {1'b0, 1'b0, 1'($urandom_range(1)), 4'($urandom_range(15, 2))};
      sw(1'b1);
      cyc(1 + $urandom_range(5));
      i_core_model.pulse(2);
      wait_pulse(1, 8);
      `CHK(wdt_reset_req, 1'b1, "early clear in window")
      @(negedge ref_clk);
      device_reset = 1'b1;
      @(negedge ref_clk);
      device_reset = 1'b0;
      cyc(1);
      `CHK(soft_enable_bit, 1'b0, "device reset clears enable")
    end
    cfg = 7'h42;
    sw(1'b1);
    i_core_model.pulse(2);
    wait_pulse(1, 20);
    `CHK(rst, 0, "clear outside window mode")
    `CHK(n, 20, "no reset pulse outside window")
    cfg = 7'h40;
    i_core_model.pulse(0);
    cyc(1);
    `CHK(in_low_power, 1'b1, "enter low power")
    cyc(200);
    @(negedge ref_clk);
    osc_switch_done = 1'b1;
    @(negedge ref_clk);
    osc_switch_done = 1'b0;
    wait_pulse(0, 32 * 3124 + 40);
    `CHK(n >= 31 * 3124 && n <= 32 * 3124 + 40, 1'b1, "divide-by-32 period")
    `CHK(rst, 0, "no reset in sleep")
    `CHK(timeout_flag, 1'b1, "flag set on wake timeout")
    cyc(2);
    `CHK(in_low_power, 1'b0, "woken")
    finish_test();
  end
endmodule
